// [logic/cg_defines.svh]
// Register offsets, reset values and field positions for the configurable GPIO block.
`ifndef CG_DEFINES_SVH
`define CG_DEFINES_SVH
`define CG_ADDR_W 8
`define CG_OFF_CH1_VALUE 8'h00
`define CG_OFF_CH1_DIR 8'h04
`define CG_OFF_CH2_VALUE 8'h08
`define CG_OFF_CH2_DIR 8'h0C
`define CG_OFF_GLOBAL_EN 8'h1C
`define CG_OFF_IRQ_ENABLE 8'h28
`define CG_OFF_IRQ_STATUS 8'h20
`define CG_GLOBAL_EN_BIT 31
`define CG_DEF_WIDTH 32
`define CG_DEF_OUT_RESET 32'h00000000
`define CG_DEF_DIR_RESET 32'hFFFFFFFF
`endif

// [logic/cg_pkg.sv]
// Types shared by the configurable GPIO block.
package cg_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cg_bus_req_s;
    typedef enum logic {
        CG_IDLE,
        CG_ANSWER
    } cg_rd_state_e;
endpackage : cg_pkg

// [logic/cg_channel.sv]
// One GPIO channel: value and direction registers, pin drive and input capture.
`timescale 1ns/1ps
`include "cg_defines.svh"
module cg_channel #(
    parameter int WIDTH = 32,
    parameter bit INPUTS_ONLY = 1'b0,
    parameter bit OUTPUTS_ONLY = 1'b0,
    parameter logic [31:0] OUT_RESET = 32'h00000000,
    parameter logic [31:0] DIR_RESET = 32'hFFFFFFFF
) (
    input wire logic clk_in,
    input wire logic srst_n_in,
    input wire logic value_wr_in,
    input wire logic dir_wr_in,
    input wire logic [31:0] wdata_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_out,
    output logic [31:0] value_rd_out,
    output logic [31:0] dir_rd_out,
    output logic event_out
);
    logic [WIDTH-1:0] value_q;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] in_q;
    logic [WIDTH-1:0] in_prev_q;
    logic primed_q;
    logic [WIDTH-1:0] in_mask;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_in) begin
                if (!srst_n_in) begin
                    value_q[i] <= OUT_RESET[i]; // R4
                    dir_q[i] <= DIR_RESET[i]; // R5
                end else begin
                    if (value_wr_in && !INPUTS_ONLY) begin
                        value_q[i] <= wdata_in[i];
                    end
                    if (dir_wr_in && !INPUTS_ONLY && !OUTPUTS_ONLY) begin
                        dir_q[i] <= wdata_in[i];
                    end
                end
            end
            // Input-only never drives; output-only always drives; else direction 0 drives.
            assign pin_oe_out[i] = INPUTS_ONLY ? 1'b0 : (OUTPUTS_ONLY ? 1'b1 : !dir_q[i]); // R2 R3 R9 R12
            assign pin_out[i] = INPUTS_ONLY ? 1'b0 : value_q[i]; // R2
            // An input-only bit watches its pin whatever its direction bit says.
            assign in_mask[i] = INPUTS_ONLY ? 1'b1 : (OUTPUTS_ONLY ? 1'b0 : dir_q[i]); // R11
        end
    endgenerate
    always_ff @(posedge clk_in) begin
        if (!srst_n_in) begin
            in_q <= '0;
            in_prev_q <= '0;
            primed_q <= 1'b0;
        end else begin
            in_q <= OUTPUTS_ONLY ? '0 : pin_in; // R3
            in_prev_q <= primed_q ? in_q : (OUTPUTS_ONLY ? '0 : pin_in);
            primed_q <= 1'b1;
        end
    end
    // The first sample after reset also loads the previous copy, so reset never fires an event.
    assign event_out = primed_q && ((in_q & in_mask) != (in_prev_q & in_mask)); // R11
    always_comb begin
        value_rd_out = '0;
        dir_rd_out = '0;
        for (int k = 0; k < WIDTH; k++) begin
            value_rd_out[k] = INPUTS_ONLY ? in_q[k] :
                (OUTPUTS_ONLY ? value_q[k] : (dir_q[k] ? in_q[k] : value_q[k]));
            dir_rd_out[k] = dir_q[k];
        end
    end
endmodule : cg_channel

// [logic/cg_gpio.sv]
// Top of the configurable GPIO block: register port, two channels and interrupt logic.
`timescale 1ns/1ps
`include "cg_defines.svh"
// Operation
// R1: Channel width parameter, 1 to 32, default 32.
// R2: Input-only option removes output drive.
// R3: Output-only option removes input capture.
// R4: Output value register reset from parameter.
// R5: Direction register reset from parameter, default inputs.
// R6: Dual option adds independent second channel.
// R7: Second channel options apply only when dual.
// R8: Interrupt option builds interrupt logic and registers.
// R9: Direction 1 is input, 0 drives.
// R10: Single clock, active-low synchronous reset.
// R11: Input transition sets status, raises interrupt.
// R12: Input-only channel never enables its outputs.
module cg_gpio #(
    parameter int CH1_WIDTH = `CG_DEF_WIDTH,
    parameter bit CH1_INPUTS_ONLY = 1'b0,
    parameter bit CH1_OUTPUTS_ONLY = 1'b0,
    parameter logic [31:0] CH1_OUT_RESET = `CG_DEF_OUT_RESET,
    parameter logic [31:0] CH1_DIR_RESET = `CG_DEF_DIR_RESET,
    parameter bit SECOND_CHANNEL_PRESENT_CFG = 1'b0,
    parameter int CHAN2_PIN_COUNT_CFG = `CG_DEF_WIDTH,
    parameter bit CH2_INPUTS_ONLY = 1'b0,
    parameter bit CH2_OUTPUTS_ONLY = 1'b0,
    parameter logic [31:0] CH2_OUT_RESET = `CG_DEF_OUT_RESET,
    parameter logic [31:0] CH2_DIR_RESET = `CG_DEF_DIR_RESET,
    parameter bit IRQ_LOGIC_PRESENT_CFG = 1'b0
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [CH1_WIDTH-1:0] ch1_pin_in,
    output logic [CH1_WIDTH-1:0] ch1_pin_out,
    output logic [CH1_WIDTH-1:0] ch1_pin_oe_out,
    input wire logic [CHAN2_PIN_COUNT_CFG-1:0] ch2_pin_in,
    output logic [CHAN2_PIN_COUNT_CFG-1:0] ch2_pin_out,
    output logic [CHAN2_PIN_COUNT_CFG-1:0] ch2_pin_oe_out,
    output logic irq_out
);
    cg_pkg::cg_bus_req_s req;
    cg_pkg::cg_rd_state_e rd_state_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] ch1_value_rd;
    logic [31:0] ch1_dir_rd;
    logic [31:0] ch2_value_rd;
    logic [31:0] ch2_dir_rd;
    logic [CH1_WIDTH-1:0] ch1_pin_d;
    logic [CH1_WIDTH-1:0] ch1_oe_d;
    logic [CHAN2_PIN_COUNT_CFG-1:0] ch2_pin_d;
    logic [CHAN2_PIN_COUNT_CFG-1:0] ch2_oe_d;
    logic [CH1_WIDTH-1:0] ch1_pin_q;
    logic [CH1_WIDTH-1:0] ch1_oe_q;
    logic [CHAN2_PIN_COUNT_CFG-1:0] ch2_pin_q;
    logic [CHAN2_PIN_COUNT_CFG-1:0] ch2_oe_q;
    logic [1:0] events;
    logic global_en_q;
    logic [1:0] irq_en_q;
    logic [1:0] irq_stat_q;
    logic irq_q;
    logic srst_n;
    logic dual;
    // The reset pin is treated as a synchronous reset sampled by the bus clock.
    assign srst_n = arst_n_in; // R10
    assign dual = SECOND_CHANNEL_PRESENT_CFG; // R6
    assign req.addr = addr_in;
    assign req.wdata = wdata_in;
    assign req.wr = wr_in;
    assign req.rd = rd_in;
    cg_channel #(
        .WIDTH(CH1_WIDTH), // R1
        .INPUTS_ONLY(CH1_INPUTS_ONLY),
        .OUTPUTS_ONLY(CH1_OUTPUTS_ONLY),
        .OUT_RESET(CH1_OUT_RESET),
        .DIR_RESET(CH1_DIR_RESET)
    ) u_ch1 (
        .clk_in(ref_clk_in),
        .srst_n_in(srst_n),
        .value_wr_in(req.wr && req.addr == `CG_OFF_CH1_VALUE),
        .dir_wr_in(req.wr && req.addr == `CG_OFF_CH1_DIR),
        .wdata_in(req.wdata),
        .pin_in(ch1_pin_in),
        .pin_out(ch1_pin_d),
        .pin_oe_out(ch1_oe_d),
        .value_rd_out(ch1_value_rd),
        .dir_rd_out(ch1_dir_rd),
        .event_out(events[0])
    );
    // When the second channel is absent, its parameters are ignored and its writes dropped.
    cg_channel #(
        .WIDTH(CHAN2_PIN_COUNT_CFG), // R1 R7
        .INPUTS_ONLY(CH2_INPUTS_ONLY || !SECOND_CHANNEL_PRESENT_CFG),
        .OUTPUTS_ONLY(CH2_OUTPUTS_ONLY && SECOND_CHANNEL_PRESENT_CFG),
        .OUT_RESET(CH2_OUT_RESET),
        .DIR_RESET(CH2_DIR_RESET)
    ) u_ch2 (
        .clk_in(ref_clk_in),
        .srst_n_in(srst_n),
        .value_wr_in(dual && req.wr && req.addr == `CG_OFF_CH2_VALUE), // R7
        .dir_wr_in(dual && req.wr && req.addr == `CG_OFF_CH2_DIR),
        .wdata_in(req.wdata),
        .pin_in(ch2_pin_in),
        .pin_out(ch2_pin_d),
        .pin_oe_out(ch2_oe_d),
        .value_rd_out(ch2_value_rd),
        .dir_rd_out(ch2_dir_rd),
        .event_out(events[1])
    );
    // Pins are registered once more so every top output comes from a flip-flop.
    always_ff @(posedge ref_clk_in) begin
        if (!srst_n) begin
            ch1_pin_q <= '0;
            ch1_oe_q <= '0;
            ch2_pin_q <= '0;
            ch2_oe_q <= '0;
        end else begin
            ch1_pin_q <= ch1_pin_d; // R9
            ch1_oe_q <= ch1_oe_d; // R9
            ch2_pin_q <= dual ? ch2_pin_d : '0; // R6
            ch2_oe_q <= dual ? ch2_oe_d : '0; // R6
        end
    end
    assign ch1_pin_out = ch1_pin_q;
    assign ch1_pin_oe_out = ch1_oe_q;
    assign ch2_pin_out = ch2_pin_q;
    assign ch2_pin_oe_out = ch2_oe_q;
    always_ff @(posedge ref_clk_in) begin
        if (!srst_n || !IRQ_LOGIC_PRESENT_CFG) begin
            global_en_q <= 1'b0; // R8
            irq_en_q <= 2'h0;
        end else if (req.wr) begin
            if (req.addr == `CG_OFF_GLOBAL_EN) begin
                global_en_q <= req.wdata[`CG_GLOBAL_EN_BIT];
            end
            if (req.addr == `CG_OFF_IRQ_ENABLE) begin
                irq_en_q <= {req.wdata[1] && dual, req.wdata[0]};
            end
        end
    end
    // Writing a one toggles a status bit; a new event in the same cycle still sets it.
    always_ff @(posedge ref_clk_in) begin
        if (!srst_n || !IRQ_LOGIC_PRESENT_CFG) begin
            irq_stat_q <= 2'h0; // R8
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (events[c] && (c == 0 || dual)) begin
                    irq_stat_q[c] <= 1'b1; // R11
                end else if (req.wr && req.addr == `CG_OFF_IRQ_STATUS && req.wdata[c]) begin
                    irq_stat_q[c] <= !irq_stat_q[c];
                end
            end
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (!srst_n || !IRQ_LOGIC_PRESENT_CFG) begin
            irq_q <= 1'b0; // R8
        end else begin
            irq_q <= global_en_q && ((irq_stat_q & irq_en_q) != 2'h0); // R11
        end
    end
    assign irq_out = irq_q;
    always_comb begin
        rdata_d = 32'h00000000;
        case (req.addr)
            `CG_OFF_CH1_VALUE: rdata_d = ch1_value_rd;
            `CG_OFF_CH1_DIR: rdata_d = ch1_dir_rd;
            `CG_OFF_CH2_VALUE: rdata_d = dual ? ch2_value_rd : 32'h00000000;
            `CG_OFF_CH2_DIR: rdata_d = dual ? ch2_dir_rd : 32'h00000000;
            `CG_OFF_GLOBAL_EN: rdata_d = {global_en_q, 31'h00000000};
            `CG_OFF_IRQ_ENABLE: rdata_d = {30'h00000000, irq_en_q};
            `CG_OFF_IRQ_STATUS: rdata_d = {30'h00000000, irq_stat_q};
            default: rdata_d = 32'h00000000;
        endcase
    end
    // Read data stand only in the cycle after the strobe and are zero otherwise.
    always_ff @(posedge ref_clk_in) begin
        if (!srst_n) begin
            rdata_q <= 32'h00000000;
            rd_state_q <= cg_pkg::CG_IDLE;
        end else begin
            rdata_q <= req.rd ? rdata_d : 32'h00000000;
            case (rd_state_q)
                cg_pkg::CG_IDLE: rd_state_q <= req.rd ? cg_pkg::CG_ANSWER : cg_pkg::CG_IDLE;
                cg_pkg::CG_ANSWER: rd_state_q <= req.rd ? cg_pkg::CG_ANSWER : cg_pkg::CG_IDLE;
                default: rd_state_q <= cg_pkg::CG_IDLE;
            endcase
        end
    end
    assign rdata_out = rdata_q;

    a_irq_follows: assert property (@(posedge ref_clk_in) disable iff (!srst_n)
        irq_q |-> $past(global_en_q) && ($past(irq_stat_q & irq_en_q) != 2'h0)) // R11
        else $error("interrupt without enabled status");
    a_irq_absent: assert property (@(posedge ref_clk_in) disable iff (!srst_n)
        !IRQ_LOGIC_PRESENT_CFG |-> !irq_q && irq_stat_q == 2'h0) // R8
        else $error("interrupt present although not built");
    a_event_sets: assert property (@(posedge ref_clk_in) disable iff (!srst_n)
        IRQ_LOGIC_PRESENT_CFG && events[0] |=> irq_stat_q[0]) // R11
        else $error("channel one event lost");
    a_ch2_quiet: assert property (@(posedge ref_clk_in) disable iff (!srst_n)
        !dual |-> ch2_oe_q == '0 && irq_stat_q[1] == 1'b0) // R6
        else $error("second channel active while absent");
    a_inonly_oe: assert property (@(posedge ref_clk_in) disable iff (!srst_n)
        (!CH1_INPUTS_ONLY || ch1_oe_q == '0) && (!CH2_INPUTS_ONLY || ch2_oe_q == '0)) // R2 R12
        else $error("input-only channel drives");
    a_outonly_oe: assert property (@(posedge ref_clk_in) disable iff (!srst_n)
        CH1_OUTPUTS_ONLY && !CH1_INPUTS_ONLY |=> ch1_oe_q == '1) // R3
        else $error("output-only channel not driving");
    a_dir_drive: assert property (@(posedge ref_clk_in) disable iff (!srst_n)
        !CH1_INPUTS_ONLY && !CH1_OUTPUTS_ONLY |=> ch1_oe_q == CH1_WIDTH'(~$past(ch1_dir_rd))) // R9
        else $error("pin enable does not follow direction");
    a_reset_dir: assert property (@(posedge ref_clk_in)
        !srst_n |=> ch1_dir_rd == 32'(CH1_DIR_RESET[CH1_WIDTH-1:0])) // R5
        else $error("direction reset value wrong");
    a_rd_once: assert property (@(posedge ref_clk_in) disable iff (!srst_n)
        rd_state_q == cg_pkg::CG_IDLE |-> rdata_q == 32'h00000000) // R10
        else $error("read data outside answer cycle");
    c_irq_raised: cover property (@(posedge ref_clk_in) disable iff (!srst_n) $rose(irq_q));
    c_status_clear: cover property (@(posedge ref_clk_in) disable iff (!srst_n) $fell(irq_stat_q[0]));
    c_pin_driven: cover property (@(posedge ref_clk_in) disable iff (!srst_n) ch1_oe_q != '0);
endmodule : cg_gpio

// [verification/cg_pin_model.sv]
// Pin-side partner: an outside driver that yields wherever the block drives.
`timescale 1ns/1ps
module cg_pin_model #(
    parameter int W = 32
) (
    input wire logic [W-1:0] pin_out_in,
    input wire logic [W-1:0] pin_oe_in,
    input wire logic [W-1:0] ext_val_in,
    output logic [W-1:0] pin_in_out
);
    // The outside world drives only the bits the block leaves undriven, so no bit floats.
    assign pin_in_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_val_in);
endmodule : cg_pin_model

// [verification/configurable_gpio_build_options_tb.sv]
// Self-checking testbench for the configurable GPIO block with two channels and interrupts.
`timescale 1ns/1ps
module configurable_gpio_build_options_tb;
    logic ref_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h00000000;
    logic [31:0] rdata_out;
    logic [31:0] p1_o, p1_oe, p1_i;
    logic [31:0] e1 = 32'h00000000;
    logic [31:0] p2_o, p2_oe, p2_i;
    logic [31:0] e2 = 32'h00000000;
    logic irq_out;
    int err_total = 0;
    int n_checks = 0;

    // Both channels keep the default full width, so the width defaults are what is exercised.
    cg_gpio #(.CH1_OUT_RESET(32'h0000005A), .CH1_DIR_RESET(32'h000000F0),
        .SECOND_CHANNEL_PRESENT_CFG(1'b1), .CH2_INPUTS_ONLY(1'b1),
        .IRQ_LOGIC_PRESENT_CFG(1'b1)) uut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .ch1_pin_in(p1_i), .ch1_pin_out(p1_o), .ch1_pin_oe_out(p1_oe),
        .ch2_pin_in(p2_i), .ch2_pin_out(p2_o), .ch2_pin_oe_out(p2_oe), .irq_out(irq_out));
    cg_pin_model pm1 (.pin_out_in(p1_o), .pin_oe_in(p1_oe), .ext_val_in(e1),
        .pin_in_out(p1_i));
    cg_pin_model pm2 (.pin_out_in(p2_o), .pin_oe_in(p2_oe), .ext_val_in(e2),
        .pin_in_out(p2_i));

    initial begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(negedge ref_clk_in);
        chk(rdata_out, exp);
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask : wait_cyc

    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(3000 * 100);
        err_total++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        wait_cyc(2);
        chk(p1_o, 32'h0000005A);
        chk(p1_oe, 32'hFFFFFF0F);
        chk(p2_oe, 32'h00000000);
        rd(8'h04, 32'h000000F0);
        $display("test reset values done");
        wr(8'h04, 32'h00000000);
        wr(8'h00, 32'hFFFFFFC3);
        wait_cyc(2);
        chk(p1_oe, 32'hFFFFFFFF);
        chk(p1_o, 32'hFFFFFFC3);
        rd(8'h00, 32'hFFFFFFC3);
        $display("test output drive done");
        @(posedge ref_clk_in);
        e1 <= 32'h000000A5;
        wr(8'h04, 32'hFFFFFFFF);
        wait_cyc(3);
        chk(p1_oe, 32'h00000000);
        rd(8'h00, 32'h000000A5);
        rd(8'h40, 32'h00000000);
        $display("test input capture done");
        wr(8'h0C, 32'h00000000);
        wr(8'h08, 32'h0000000F);
        @(posedge ref_clk_in);
        e2 <= 32'h00000009;
        wait_cyc(3);
        chk(p2_oe, 32'h00000000);
        chk(p2_o, 32'h00000000);
        rd(8'h08, 32'h00000009);
        rd(8'h0C, 32'hFFFFFFFF);
        // Channel one is flagged too: its pins turned to inputs and saw a new level.
        rd(8'h20, 32'h00000003);
        wr(8'h20, 32'h00000003);
        rd(8'h20, 32'h00000000);
        $display("test second channel done");
        wr(8'h28, 32'h00000003);
        wr(8'h1C, 32'h80000000);
        rd(8'h1C, 32'h80000000);
        @(posedge ref_clk_in);
        e1 <= 32'h0000005A;
        wait_cyc(6);
        chk({31'h0, irq_out}, 32'h1);
        rd(8'h20, 32'h00000001);
        wr(8'h20, 32'h00000001);
        wait_cyc(2);
        chk({31'h0, irq_out}, 32'h0);
        wr(8'h28, 32'h00000002);
        @(posedge ref_clk_in);
        e1 <= 32'h00000000;
        wait_cyc(6);
        chk({31'h0, irq_out}, 32'h0);
        rd(8'h20, 32'h00000001);
        wr(8'h28, 32'h00000003);
        wait_cyc(2);
        chk({31'h0, irq_out}, 32'h1);
        wr(8'h1C, 32'h00000000);
        wait_cyc(2);
        chk({31'h0, irq_out}, 32'h0);
        wr(8'h1C, 32'h80000000);
        wait_cyc(2);
        chk({31'h0, irq_out}, 32'h1);
        $display("test interrupts done");
        wr(8'h04, 32'h00000000);
        @(posedge ref_clk_in);
        arst_n_in <= 1'b0;
        wait_cyc(2);
        chk({31'h0, irq_out}, 32'h0);
        @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        wait_cyc(2);
        chk(p1_oe, 32'hFFFFFF0F);
        chk(p1_o, 32'h0000005A);
        rd(8'h04, 32'h000000F0);
        rd(8'h1C, 32'h00000000);
        rd(8'h28, 32'h00000000);
        rd(8'h20, 32'h00000000);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule : configurable_gpio_build_options_tb
